// ==== bench/dgc_zone_model.sv ====
// Far-side model: zone storage and hash engine, each answering a held request with a one-cycle pulse.
// Assumes the handler holds every request until it has seen the answer pulse.
`timescale 1ns/1ps
module dgc_zone_model (
	// Clock and pace
	input  wire logic         clk_i,
	input  wire logic         slow_i,
	// Zone fetch
	input  wire logic         f_req_i,
	input  wire logic [1:0]   f_zone_i,
	input  wire logic [7:0]   f_idx_i,
	output logic              f_ack_o,
	output logic [255:0]      f_data_o,
	output logic              f_nomac_o,
	// Hash engine
	input  wire logic         h_req_i,
	input  wire logic [767:0] h_msg_i,
	output logic              h_done_o,
	output logic [255:0]      h_dig_o
);
	logic [2:0] cnt = 3'h0;
	initial {f_ack_o, f_data_o, f_nomac_o, h_done_o, h_dig_o} = '0;
	always @(posedge clk_i) begin
		f_ack_o <= 1'b0;
		h_done_o <= 1'b0;
		// Idle buses toggle so that a stale block is never mistaken for data
		f_data_o <= ~f_data_o;
		h_dig_o <= ~h_dig_o;
		cnt <= (f_req_i || h_req_i) ? cnt + 3'h1 : 3'h0;
		if (f_req_i && !f_ack_o && cnt >= {1'b0, slow_i, 1'b0}) begin
			f_ack_o <= 1'b1;
			cnt <= 3'h0;
			f_data_o <= {8{f_zone_i, f_idx_i[5:0], 24'h9e3779}};
			f_nomac_o <= (f_zone_i == 2'h2) && f_idx_i[0];
		end
		if (h_req_i && !h_done_o && cnt >= {1'b0, slow_i, 1'b0}) begin
			h_done_o <= 1'b1;
			cnt <= 3'h0;
			h_dig_o <= h_msg_i[767:512] ^ {h_msg_i[510:256], h_msg_i[511]} ^ ~h_msg_i[255:0];
		end
	end
endmodule

// ==== bench/tb_dgc_digest_gen.sv ====
// Self-checking bench: drives commands and nonce loads, queues expected results and messages.
// Assumes the zone/hash model in dgc_zone_model and the handler's hand-over timing.
`timescale 1ns/1ps
module tb_dgc_digest_gen;
	localparam logic [23:0] SER = 24'h112233; // Arbitrary serial bytes
	typedef struct packed {logic [7:0] code; logic v, ss, mf; logic [7:0] slot; logic [255:0] dig;} dgc_exp_s;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, nonce_load_i = 1'b0, slow = 1'b0, hq = 1'b0;
	dgc_pkg::dgc_cmd_s cmd_i = '0;
	logic [255:0] nonce_value_i = '0, fdata, hdig, sdig, dig = '0;
	logic [767:0] hmsg;
	logic [7:0] rcode, fidx, sslot, slot = '0;
	logic [1:0] fzone;
	logic ready, rvalid, freq, fack, fnm, hreq, hdone, vflag, ssflag, mfflag, val = 0, ss = 0, mf = 0;
	logic [15:0] r = 16'h0846;
	int miscompares = 0, num_checks = 0, i;
	dgc_exp_s eq[$], e;
	logic [767:0] mq[$];
	always #12.5 sys_clk_i = ~sys_clk_i;
	dgc_digest_gen #(.SERIAL_BYTE8(SER[23:16]), .SERIAL_BYTE0(SER[15:8]), .SERIAL_BYTE1(SER[7:0])) i_dgc_digest_gen (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(ready),
		.resp_valid_o(rvalid), .resp_code_o(rcode), .nonce_load_i(nonce_load_i), .nonce_value_i(nonce_value_i),
		.fetch_req_o(freq), .fetch_zone_o(fzone), .fetch_index_o(fidx), .fetch_ack_i(fack), .fetch_data_i(fdata),
		.fetch_nomac_i(fnm), .hash_req_o(hreq), .hash_msg_o(hmsg), .hash_done_i(hdone), .hash_digest_i(hdig),
		.session_digest_o(sdig), .digest_valid_flag_o(vflag), .slot_source_flag_o(ssflag),
		.mac_forbidden_flag_o(mfflag), .source_slot_o(sslot));
	dgc_zone_model i_dgc_zone_model (.clk_i(sys_clk_i), .slow_i(slow), .f_req_i(freq), .f_zone_i(fzone),
		.f_idx_i(fidx), .f_ack_o(fack), .f_data_o(fdata), .f_nomac_o(fnm), .h_req_i(hreq), .h_msg_i(hmsg),
		.h_done_o(hdone), .h_dig_o(hdig));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input string n, input logic [767:0] x, input logic [767:0] g);
		num_checks++;
		if (x !== g) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic results();
		if (miscompares == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic idle_wait();
		@(negedge sys_clk_i);
		for (int n = 0; n < 60 && ready !== 1'b1; n++) @(negedge sys_clk_i);
		if (ready !== 1'b1) chk("ready", 1, ready);
	endtask
	task automatic send(input logic [7:0] op, input logic [7:0] md, input logic [7:0] sl, input logic ap);
		logic ok, nm;
		logic [767:0] m;
		r = lfsr(r);
		nm = (md == dgc_pkg::MODE_SLOT) && sl[0];
		ok = op == dgc_pkg::OPC_DIGEST_GEN && ((md == dgc_pkg::MODE_CONFIG && sl <= dgc_pkg::CFG_LAST_BLOCK)
			|| (md == dgc_pkg::MODE_OTP && sl <= dgc_pkg::OTP_LAST_BLOCK) || (md == dgc_pkg::MODE_SLOT && sl < 8'h10));
		if (!ok || (val && nm && !ap)) begin
			val = 1'b0;
			eq.push_back({dgc_pkg::RESP_ERR_PARSE, 1'b0, 10'h0, 256'h0});
		end else if (!val) eq.push_back({dgc_pkg::RESP_ERR_EXEC, 1'b0, 10'h0, 256'h0});
		else begin
			m = {{8{md[1:0], sl[5:0], 24'h9e3779}}, nm ? {r, ~r} : {op, md == 8'h01 ? 8'h00 : md, sl, 8'h00},
				SER, 200'h0, dig};
			mq.push_back(m);
			dig = m[767:512] ^ {m[510:256], m[511]} ^ ~m[255:0];
			ss = (md == dgc_pkg::MODE_SLOT);
			if (ss) {mf, slot} = {nm, sl};
			eq.push_back({dgc_pkg::RESP_OK, 1'b1, ss, mf, slot, dig});
		end
		idle_wait();
		slow = r[0];
		cmd_i = {op, md, 8'h00, sl, r, ~r, ap};
		cmd_valid_i = 1'b1;
		@(negedge sys_clk_i);
		cmd_valid_i = 1'b0;
	endtask
	task automatic nonce();
		idle_wait();
		r = lfsr(r);
		nonce_value_i = {16{r}};
		nonce_load_i = 1'b1;
		@(negedge sys_clk_i);
		nonce_load_i = 1'b0;
		{dig, val, mf} = {nonce_value_i, 2'b10};
	endtask
	always @(negedge sys_clk_i) begin
		if (rvalid === 1'b1) begin
			if (eq.size() == 0) chk("response count", 0, 1);
			else begin
				e = eq.pop_front();
				chk("resp_code", e.code, rcode);
				chk("valid_flag", e.v, vflag);
				if (e.code === 8'h00) begin
					chk("digest", e.dig, sdig);
					chk("flags", {e.ss, e.mf, e.slot}, {ssflag, mfflag, sslot});
				end
			end
		end
		if (hreq === 1'b1 && !hq) chk("message", mq.size() ? mq.pop_front() : 768'h1, hmsg);
		hq <= (hreq === 1'b1);
	end
	initial begin
		#150000;
		miscompares++;
		results();
	end
	initial begin
		repeat (5) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		send(8'h15, 8'h00, 8'h00, 1'b0);
		nonce();
		for (i = 0; i < 5; i++) send(8'h15, 8'h00, 8'(i), 1'b0);
		send(8'h15, 8'h00, 8'h01, 1'b0);
		nonce();
		for (i = 0; i < 3; i++) send(8'h15, 8'h01, 8'(i), 1'b0);
		nonce();
		send(8'h15, 8'h02, 8'h05, 1'b1);
		send(8'h15, 8'h00, 8'h02, 1'b0);
		send(8'h15, 8'h02, 8'h0c, 1'b0);
		send(8'h15, 8'h02, 8'h07, 1'b0);
		nonce();
		send(8'h15, 8'h04, 8'h00, 1'b0);
		nonce();
		send(8'h16, 8'h00, 8'h00, 1'b0);
		repeat (20) @(negedge sys_clk_i);
		chk("queues empty", 0, eq.size() + mq.size());
		results();
	end
endmodule

// ==== rtl/dgc_digest_gen.sv ====
// Digest-generate command handler: fetches one 32-byte block, builds the
// 96-byte message and chains the hash result into the session digest.
// Assumes an external SHA-256 engine and zone storage with req/ack handshakes.
`timescale 1ns/1ps

// Operation
// - Hash stored block with validated session digest
// - Mode byte selects the data source
// - Result replaces session digest, chaining
// - Config: opcode 0x15, mode 0, block 0-3
// - Config: exactly one 32-byte block
// - OTP: mode 1, block 0 or 1
// - One response byte, zero on success
// - Valid flag set on success, cleared on failure
// - Config/OTP clear slot source flag
// - Config message layout in fixed order
// - OTP message same, mode byte zero
// - Slot source uses lowest block only
// - Digest offered to later commands
// - Slot: mode 2, aux bytes if forbidden
// - Slot sets MAC-forbidden flag, records slot
module dgc_digest_gen #(
	parameter logic [7:0] SERIAL_BYTE8 = 8'h5a, // Arbitrary value
	parameter logic [7:0] SERIAL_BYTE0 = 8'ha5, // Arbitrary value
	parameter logic [7:0] SERIAL_BYTE1 = 8'h3c  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                                sys_clk_i,
	input  wire logic                                rst_n_i,
	// Command in, response out
	input  wire logic                                cmd_valid_i,
	input  wire dgc_pkg::dgc_cmd_s                   cmd_i,
	output logic                                     cmd_ready_o,
	output logic                                     resp_valid_o,
	output logic [7:0]                               resp_code_o,
	// Nonce loading of the session digest
	input  wire logic                                nonce_load_i,
	input  wire logic [dgc_pkg::BLOCK_BITS-1:0]      nonce_value_i,
	// Zone storage fetch
	output logic                                     fetch_req_o,
	output logic [1:0]                               fetch_zone_o,
	output logic [7:0]                               fetch_index_o,
	input  wire logic                                fetch_ack_i,
	input  wire logic [dgc_pkg::BLOCK_BITS-1:0]      fetch_data_i,
	input  wire logic                                fetch_nomac_i,
	// Hash engine
	output logic                                     hash_req_o,
	output logic [dgc_pkg::MSG_BITS-1:0]             hash_msg_o,
	input  wire logic                                hash_done_i,
	input  wire logic [dgc_pkg::BLOCK_BITS-1:0]      hash_digest_i,
	// Session digest state
	output logic [dgc_pkg::BLOCK_BITS-1:0]           session_digest_o,
	output logic                                     digest_valid_flag_o,
	output logic                                     slot_source_flag_o,
	output logic                                     mac_forbidden_flag_o,
	output logic [7:0]                               source_slot_o
);

	dgc_pkg::dgc_regs_s q, d;
	logic               sel_ok;
	logic [31:0]        mid_bytes;
	logic [7:0]         msg_mode;

	// Selector range check per source
	always_comb begin
		sel_ok = 1'b0;
		if (cmd_i.selector[15:8] == dgc_pkg::SEL_HIGH_BYTE) begin
			case (cmd_i.mode)
				dgc_pkg::MODE_CONFIG: sel_ok = cmd_i.selector[7:0] <= dgc_pkg::CFG_LAST_BLOCK;
				dgc_pkg::MODE_OTP:    sel_ok = cmd_i.selector[7:0] <= dgc_pkg::OTP_LAST_BLOCK;
				dgc_pkg::MODE_SLOT:   sel_ok = cmd_i.selector[7:0] < 8'(dgc_pkg::NUM_SLOTS);
				default:              sel_ok = 1'b0;
			endcase
		end
	end

	always_comb begin
		d        = q;
		d.resp_v = 1'b0;
		case (q.state)
			dgc_pkg::ST_IDLE: begin
				if (cmd_valid_i) begin
					d.mode   = cmd_i.mode;
					d.sel    = cmd_i.selector[7:0];
					d.aux    = cmd_i.aux_bytes;
					d.aux_ok = cmd_i.aux_present;
					// Digest must be seeded by a nonce and still valid
					if (cmd_i.opcode != dgc_pkg::OPC_DIGEST_GEN || !sel_ok) begin
						d.resp_v = 1'b1;
						d.resp   = dgc_pkg::RESP_ERR_PARSE;
						d.valid  = 1'b0;
					end else if (!q.valid) begin
						d.resp_v = 1'b1;
						d.resp   = dgc_pkg::RESP_ERR_EXEC;
					end else begin
						d.state = dgc_pkg::ST_FETCH;
					end
				end else if (nonce_load_i) begin
					d.digest   = nonce_value_i;
					d.valid    = 1'b1;
					d.slot_src = 1'b0;
					d.mac_forb = 1'b0;
				end
			end
			dgc_pkg::ST_FETCH: begin
				if (fetch_ack_i) begin
					// One block per command; for slots the lowest block only
					d.block = fetch_data_i;
					d.nomac = q.mode == dgc_pkg::MODE_SLOT && fetch_nomac_i;
					if (d.nomac && !q.aux_ok) begin
						// Forbidden slot without its auxiliary bytes cannot be hashed
						d.state  = dgc_pkg::ST_IDLE;
						d.resp_v = 1'b1;
						d.resp   = dgc_pkg::RESP_ERR_PARSE;
						d.valid  = 1'b0;
					end else begin
						d.state = dgc_pkg::ST_HASH;
					end
				end
			end
			dgc_pkg::ST_HASH: begin
				if (hash_done_i) begin
					d.state  = dgc_pkg::ST_IDLE;
					d.digest = hash_digest_i;
					d.valid  = 1'b1;
					d.resp_v = 1'b1;
					d.resp   = dgc_pkg::RESP_OK;
					if (q.mode == dgc_pkg::MODE_SLOT) begin
						d.slot_src = 1'b1;
						d.mac_forb = q.nomac;
						d.slot     = q.sel;
					end else begin
						d.slot_src = 1'b0;
						// Forbidden status is sticky over a chain of commands
					end
				end
			end
			default: d.state = dgc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Message assembly from registered fields
	always_comb begin
		msg_mode = (q.mode == dgc_pkg::MODE_OTP) ? dgc_pkg::MSG_MODE_OTP : q.mode;
		if (q.nomac) begin
			mid_bytes = q.aux;
		end else begin
			mid_bytes = {dgc_pkg::OPC_DIGEST_GEN, msg_mode, q.sel, dgc_pkg::SEL_HIGH_BYTE};
		end
	end

	assign hash_msg_o = {q.block, mid_bytes, SERIAL_BYTE8, SERIAL_BYTE0, SERIAL_BYTE1,
		{dgc_pkg::PAD_BITS{1'b0}}, q.digest};

	assign cmd_ready_o          = q.state == dgc_pkg::ST_IDLE;
	assign fetch_req_o          = q.state == dgc_pkg::ST_FETCH;
	assign fetch_index_o        = q.sel;
	assign fetch_zone_o         = q.mode == dgc_pkg::MODE_CONFIG ? dgc_pkg::ZONE_CONFIG :
	                              q.mode == dgc_pkg::MODE_OTP ? dgc_pkg::ZONE_OTP : dgc_pkg::ZONE_SLOT;
	assign hash_req_o           = q.state == dgc_pkg::ST_HASH;
	assign resp_valid_o         = q.resp_v;
	assign resp_code_o          = q.resp;
	assign session_digest_o     = q.digest;
	assign digest_valid_flag_o  = q.valid;
	assign slot_source_flag_o   = q.slot_src;
	assign mac_forbidden_flag_o = q.mac_forb;
	assign source_slot_o        = q.slot;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_hash_needs_valid;
		hash_req_o |-> digest_valid_flag_o;
	endproperty
	a_hash_needs_valid: assert property (p_hash_needs_valid) else $error("hash with invalid digest");

	property p_chain;
		hash_req_o && hash_done_i |=> session_digest_o == $past(hash_digest_i) && !hash_req_o;
	endproperty
	a_chain: assert property (p_chain) else $error("digest not chained");

	property p_ok_sets_valid;
		resp_valid_o && resp_code_o == dgc_pkg::RESP_OK |-> digest_valid_flag_o && $past(hash_req_o);
	endproperty
	a_ok_sets_valid: assert property (p_ok_sets_valid) else $error("success without hash");

	property p_fail_clears;
		resp_valid_o && resp_code_o != dgc_pkg::RESP_OK |-> !digest_valid_flag_o;
	endproperty
	a_fail_clears: assert property (p_fail_clears) else $error("valid left set on failure");

	property p_src_flag;
		resp_valid_o && resp_code_o == dgc_pkg::RESP_OK && q.mode != dgc_pkg::MODE_SLOT |-> !slot_source_flag_o;
	endproperty
	a_src_flag: assert property (p_src_flag) else $error("slot flag not cleared");

	property p_cfg_msg;
		hash_req_o && q.mode == dgc_pkg::MODE_CONFIG |->
			hash_msg_o[511:480] == {dgc_pkg::OPC_DIGEST_GEN, 8'h00, q.sel, 8'h00} && hash_msg_o[255:0] == session_digest_o;
	endproperty
	a_cfg_msg: assert property (p_cfg_msg) else $error("config message layout");

	property p_otp_mode;
		hash_req_o && q.mode == dgc_pkg::MODE_OTP |-> hash_msg_o[503:496] == dgc_pkg::MSG_MODE_OTP;
	endproperty
	a_otp_mode: assert property (p_otp_mode) else $error("otp mode byte");

	property p_slot_flags;
		resp_valid_o && resp_code_o == dgc_pkg::RESP_OK && q.mode == dgc_pkg::MODE_SLOT |->
			slot_source_flag_o && mac_forbidden_flag_o == q.nomac && source_slot_o == q.sel;
	endproperty
	a_slot_flags: assert property (p_slot_flags) else $error("slot flags wrong");

	property p_reject;
		cmd_ready_o && cmd_valid_i && !digest_valid_flag_o |=> resp_valid_o && resp_code_o != dgc_pkg::RESP_OK;
	endproperty
	a_reject: assert property (p_reject) else $error("invalid digest not rejected");

	property p_one_block;
		fetch_req_o && fetch_ack_i |=> !fetch_req_o;
	endproperty
	a_one_block: assert property (p_one_block) else $error("second block fetched");

	c_cfg_ok:   cover property (hash_req_o && hash_done_i && q.mode == dgc_pkg::MODE_CONFIG);
	c_otp_ok:   cover property (hash_req_o && hash_done_i && q.mode == dgc_pkg::MODE_OTP);
	c_slot_nm:  cover property (hash_req_o && hash_done_i && q.nomac);
	c_rejected: cover property (resp_valid_o && resp_code_o != dgc_pkg::RESP_OK);

endmodule

// ==== rtl/dgc_pkg.sv ====
// Constants and carrier types for the digest-generate command handler.
// Assumes a single 40 MHz core clock; the hash engine and zone storage sit outside.
package dgc_pkg;

	// Command encoding
	localparam logic [7:0] OPC_DIGEST_GEN = 8'h15;
	localparam logic [7:0] MODE_CONFIG    = 8'h00;
	localparam logic [7:0] MODE_OTP       = 8'h01;
	localparam logic [7:0] MODE_SLOT      = 8'h02;
	// Mode byte placed in the hash message for the OTP source, as printed
	localparam logic [7:0] MSG_MODE_OTP   = 8'h00;

	// Source ranges
	localparam logic [7:0] CFG_LAST_BLOCK = 8'h03;
	localparam logic [7:0] OTP_LAST_BLOCK = 8'h01;
	localparam int         NUM_SLOTS      = 16;

	// Fetch zone codes
	localparam logic [1:0] ZONE_CONFIG = 2'h0;
	localparam logic [1:0] ZONE_OTP    = 2'h1;
	localparam logic [1:0] ZONE_SLOT   = 2'h2;

	// Response codes; the error values are arbitrary
	localparam logic [7:0] RESP_OK        = 8'h00;
	localparam logic [7:0] RESP_ERR_PARSE = 8'h03;
	localparam logic [7:0] RESP_ERR_EXEC  = 8'h0f;

	// Message layout
	localparam int BLOCK_BITS = 256;
	localparam int MSG_BITS   = 768;
	localparam int PAD_BITS   = 200;
	localparam logic [7:0] SEL_HIGH_BYTE = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_HASH
	} dgc_state_e;

	typedef struct packed {
		logic [7:0]  opcode;
		logic [7:0]  mode;
		logic [15:0] selector;
		logic [31:0] aux_bytes;
		logic        aux_present;
	} dgc_cmd_s;

	typedef struct packed {
		dgc_state_e                  state;
		logic [7:0]                  mode;
		logic [7:0]                  sel;
		logic [31:0]                 aux;
		logic                        aux_ok;
		logic [BLOCK_BITS-1:0]       block;
		logic                        nomac;
		logic [BLOCK_BITS-1:0]       digest;
		logic                        valid;
		logic                        slot_src;
		logic                        mac_forb;
		logic [7:0]                  slot;
		logic                        resp_v;
		logic [7:0]                  resp;
	} dgc_regs_s;

endpackage
